/* File: logic/canbf_pkg.sv */
// Constants and types shared by the CAN bit timing and frame core.
// Assumes a 32-bit APB master and a wired-AND CAN transceiver outside.
// How it works
// - Resync stretches pre-sample or shrinks post-sample by at most jump width.
// - Phase error is zero in sync segment, positive before, negative after.
// - Error within jump width restarts bit timing like a hard sync.
// - Larger positive error lengthens the bit by exactly the jump width.
// - Larger negative error shortens the bit by exactly the jump width; here by one cycle less when the error is jump width plus one.
// - At most one synchronization per bit time.
// - Edge counts only if new level differs from last sampled level.
// - Falling edge during bus idle forces a hard synchronization.
// - Resync on falling edges, rising ones too when both-edge bit set.
// - Transmitter ignores positive-error falling edges in falling-only mode.
// - Bus is wired-AND; dominant wins, recessive only if all recessive.
// - Frame starts with one dominant start bit; receivers hard sync.
// - Identifier is eleven bits, most significant bit first.
// - Remote bit follows identifier; recessive for remote, dominant for data.
// - Control field: two dominant reserved bits, then four-bit length code.
// - Length code 0 to 8 gives byte count; zero dominant, one recessive.
// - Data kept byte-wise; lowest byte's most significant bit goes first.
// - Fifteen-bit CRC, most significant first, then one recessive delimiter.
// - Transmitter sends ack recessive; good receivers drive ack slot dominant.
// - Seven recessive end bits; stuffing only up to CRC end.
// - Sync segment is one clock cycle at bit start.
// - Sample at end of pre-sample segment, 1 to 16 cycles.
// - Post-sample segment spans 1 to 8 cycles.
package canbf_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIM = 8'h04;
  localparam logic [7:0] ADDR_TXID = 8'h08;
  localparam logic [7:0] ADDR_TXD0 = 8'h0C;
  localparam logic [7:0] ADDR_TXD1 = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_RXID = 8'h18;
  localparam logic [7:0] ADDR_RXD0 = 8'h1C;
  localparam logic [7:0] ADDR_RXD1 = 8'h20;
  localparam int CTRL_BOTH = 0;
  localparam int CTRL_SEND = 1;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int TIM_PRE = 0;
  localparam int TIM_POST = 4;
  localparam int TIM_SJW = 8;
  localparam logic [31:0] TIM_MASK = 32'h0000_037F;
  localparam logic [31:0] TIM_RST = 32'h0000_0137;
  localparam int ID_LSB = 0;
  localparam int RTR_BIT = 11;
  localparam int DLC_LSB = 12;
  localparam logic [31:0] TXID_MASK = 32'h0000_FFFF;
  localparam int ST_IDLE = 0;
  localparam int ST_TXBUSY = 1;
  localparam int ST_TXDONE = 2;
  localparam int ST_ACK = 3;
  localparam int ST_RXVAL = 4;
  localparam int ST_ERR = 5;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [5:0] ID_LAST = 6'h0A;
  localparam logic [5:0] RES_LAST = 6'h01;
  localparam logic [5:0] DLC_LAST = 6'h03;
  localparam logic [5:0] CRC_LAST = 6'h0E;
  localparam logic [5:0] EOF_LAST = 6'h06;
  localparam logic [5:0] INT_LAST = 6'h02;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  typedef enum logic [1:0] {SEG_SYNC, SEG_ONE, SEG_TWO} canbf_seg_t;
  typedef enum logic [3:0] {F_IDLE, F_SOF, F_ID, F_RTR, F_RES, F_DLC,
    F_DATA, F_CRC, F_CRCD, F_ACK, F_ACKD, F_EOF, F_INT} canbf_fld_t;
endpackage : canbf_pkg

/* File: logic/canbf_core.sv */
// CAN bit timing, resynchronization and data frame engine with APB registers.
// Assumes an APB master on clk_sys_i and a wired-AND transceiver on the bus.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module canbf_core (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic can_rx_i,
  output logic can_tx_o
);
  import canbf_pkg::*;

  logic [31:0] ctrl_r, tim_r, txid_r, rd_c;
  logic [63:0] txd_r, rxd_r;
  logic [10:0] rx_id_r;
  logic rx_rtr_r;
  logic [3:0] rx_dlc_r, nb_r;
  logic send_r, done_r, ack_r, rxv_r, err_r;
  logic rx_m_r, rx_s_r, rx_d_r, samp_r, synced_r;
  canbf_seg_t seg_r;
  canbf_fld_t fld_r;
  logic [4:0] cnt_r, ext_r, shr_r, len1, len2, sjw_len, e_mag;
  logic [5:0] fcnt_r;
  logic [2:0] run_r;
  logic [14:0] crc_r;
  logic last_r, tx_act_r, ok_r, tx_bit_c, drive_c;
  logic fall, rise, cand, both, hard_ev, res_ev, skip_c, restart;
  logic lengthen, shorten, sample, tx_upd, in_stuff, stuff_now, b;
  logic err_ev, ack_ev, end_ev, wr_en, rd_setup, mapped;

  function automatic logic [31:0] wmerge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction : wmerge

  function automatic logic [14:0] crc_step(input logic [14:0] c,
      input logic d);
    crc_step = {c[13:0], 1'b0} ^ ((d ^ c[14]) ? CRC_POLY : 15'h0000);
  endfunction : crc_step

  // Bit position of data bit n: byte n/8 low address first, MSB first
  function automatic logic [5:0] bit_idx(input logic [5:0] n);
    bit_idx = {n[5:3], ~n[2:0]};
  endfunction : bit_idx

  function automatic logic [3:0] n_bytes(input logic rtr,
      input logic [3:0] dlc);
    n_bytes = rtr ? 4'h0 : (dlc > MAX_BYTES ? MAX_BYTES : dlc);
  endfunction : n_bytes

  // APB slave: zero wait states, but ce_i low stalls the access
  assign pready_o = ce_i;
  assign wr_en = psel_i & penable_i & pwrite_i & ce_i;
  assign rd_setup = psel_i & ~penable_i & ce_i;
  assign mapped = paddr_i inside {ADDR_CTRL, ADDR_TIM, ADDR_TXID,
    ADDR_TXD0, ADDR_TXD1, ADDR_STAT, ADDR_RXID, ADDR_RXD0, ADDR_RXD1};
  assign pslverr_o = psel_i & penable_i & ~mapped;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
      tim_r <= TIM_RST;
      txid_r <= 32'h0000_0000;
      txd_r <= '0;
    end else if (wr_en) begin
      case (paddr_i)
        ADDR_CTRL: ctrl_r <= wmerge(ctrl_r, pwdata_i, pstrb_i) & CTRL_MASK;
        ADDR_TIM: tim_r <= wmerge(tim_r, pwdata_i, pstrb_i) & TIM_MASK;
        ADDR_TXID: txid_r <= wmerge(txid_r, pwdata_i, pstrb_i) & TXID_MASK;
        ADDR_TXD0: txd_r[31:0] <= wmerge(txd_r[31:0], pwdata_i, pstrb_i);
        ADDR_TXD1: txd_r[63:32] <= wmerge(txd_r[63:32], pwdata_i, pstrb_i);
        default: ;
      endcase
    end
  end

  always_comb begin
    case (paddr_i)
      ADDR_CTRL: rd_c = ctrl_r;
      ADDR_TIM: rd_c = tim_r;
      ADDR_TXID: rd_c = txid_r;
      ADDR_TXD0: rd_c = txd_r[31:0];
      ADDR_TXD1: rd_c = txd_r[63:32];
      ADDR_STAT: rd_c = {26'h0, err_r, rxv_r, ack_r, done_r,
        tx_act_r | send_r, fld_r == F_IDLE};
      ADDR_RXID: rd_c = {16'h0000, rx_dlc_r, rx_rtr_r, rx_id_r};
      ADDR_RXD0: rd_c = rxd_r[31:0];
      ADDR_RXD1: rd_c = rxd_r[63:32];
      default: rd_c = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle so it is a flip-flop output
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= rd_c;
    end
  end

  // Status flags: hardware set wins over a write-one clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_r <= 1'b0;
      ack_r <= 1'b0;
      rxv_r <= 1'b0;
      err_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_en && paddr_i == ADDR_STAT && pstrb_i[0]) begin
        done_r <= done_r & ~pwdata_i[ST_TXDONE];
        ack_r <= ack_r & ~pwdata_i[ST_ACK];
        rxv_r <= rxv_r & ~pwdata_i[ST_RXVAL];
        err_r <= err_r & ~pwdata_i[ST_ERR];
      end
      if (end_ev & tx_act_r)
        done_r <= 1'b1;
      if (ack_ev)
        ack_r <= 1'b1;
      if (end_ev & ~tx_act_r & ok_r)
        rxv_r <= 1'b1;
      if (err_ev)
        err_r <= 1'b1;
    end
  end

  // Send request: set by software, taken when the frame starts
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      send_r <= 1'b0;
    end else if (ce_i) begin
      if (sample && fld_r == F_IDLE && b)
        send_r <= 1'b0;
      if (wr_en && paddr_i == ADDR_CTRL && pstrb_i[0] && pwdata_i[CTRL_SEND])
        send_r <= 1'b1;
    end
  end

  // Bus input passes two flops; rx_d_r is the previous synced level
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_d_r <= 1'b1;
    end else if (ce_i) begin
      rx_m_r <= can_rx_i;
      rx_s_r <= rx_m_r;
      rx_d_r <= rx_s_r;
    end
  end

  assign both = ctrl_r[CTRL_BOTH];
  assign sjw_len = 5'(tim_r[TIM_SJW +: 2]) + 5'h01;
  assign len1 = 5'(tim_r[TIM_PRE +: 4]) + 5'h01 + ext_r;
  assign len2 = 5'(tim_r[TIM_POST +: 3]) + 5'h01;
  assign b = rx_s_r;
  assign fall = rx_d_r & ~rx_s_r;
  assign rise = ~rx_d_r & rx_s_r;

  always_comb begin
    unique case (seg_r)
      SEG_SYNC: e_mag = 5'h00;
      SEG_ONE: e_mag = cnt_r + 5'h01;
      SEG_TWO: e_mag = len2 - cnt_r;
    endcase
  end

  assign cand = ce_i & ~synced_r & (rx_s_r != samp_r);
  assign hard_ev = cand & fall & (fld_r == F_IDLE);
  assign skip_c = tx_act_r & ~both & fall & (seg_r == SEG_ONE);
  assign res_ev = cand & (fld_r != F_IDLE) & (fall | (rise & both)) &
    ~skip_c;
  assign restart = hard_ev | (res_ev & (e_mag <= sjw_len));
  assign lengthen = res_ev & (seg_r == SEG_ONE) & (e_mag > sjw_len);
  assign shorten = res_ev & (seg_r == SEG_TWO) & (e_mag > sjw_len);
  assign sample = ce_i & ~restart & ~lengthen & (seg_r == SEG_ONE) &
    (cnt_r + 5'h01 >= len1);
  assign tx_upd = ce_i & ((seg_r == SEG_SYNC & ~restart) |
    (restart & seg_r == SEG_TWO));

  // Bit timer; a restart treats the edge cycle as the sync segment
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_r <= SEG_SYNC;
      cnt_r <= 5'h00;
      ext_r <= 5'h00;
      shr_r <= 5'h00;
    end else if (ce_i) begin
      if (restart) begin
        seg_r <= SEG_ONE;
        cnt_r <= 5'h00;
        ext_r <= 5'h00;
        shr_r <= 5'h00;
      end else begin
        unique case (seg_r)
          SEG_SYNC: begin
            seg_r <= SEG_ONE;
            cnt_r <= 5'h00;
          end
          SEG_ONE: begin
            if (lengthen) begin
              ext_r <= sjw_len;
              cnt_r <= cnt_r + 5'h01;
            end else if (sample) begin
              seg_r <= SEG_TWO;
              cnt_r <= 5'h00;
              ext_r <= 5'h00;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
          SEG_TWO: begin
            if (shorten) begin
              shr_r <= sjw_len;
              cnt_r <= cnt_r + 5'h01;
            end else if (cnt_r + 5'h01 + shr_r >= len2) begin
              seg_r <= SEG_SYNC;
              cnt_r <= 5'h00;
              shr_r <= 5'h00;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
        endcase
      end
    end
  end

  // One synchronization per bit; the flag clears at a natural bit start
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      synced_r <= 1'b0;
      samp_r <= 1'b1;
    end else if (ce_i) begin
      if (restart | lengthen | shorten)
        synced_r <= 1'b1;
      else if (seg_r == SEG_SYNC)
        synced_r <= 1'b0;
      if (sample)
        samp_r <= rx_s_r;
    end
  end

  assign in_stuff = fld_r inside {F_SOF, F_ID, F_RTR, F_RES, F_DLC,
    F_DATA, F_CRC};
  assign stuff_now = in_stuff & (run_r == STUFF_RUN);

  always_comb begin
    tx_bit_c = 1'b1;
    if (stuff_now)
      tx_bit_c = ~last_r;
    else begin
      case (fld_r)
        F_SOF: tx_bit_c = 1'b0;
        F_ID: tx_bit_c = txid_r[ID_LSB + 10 - int'(fcnt_r)];
        F_RTR: tx_bit_c = txid_r[RTR_BIT];
        F_RES: tx_bit_c = 1'b0;
        F_DLC: tx_bit_c = txid_r[DLC_LSB + 3 - int'(fcnt_r)];
        F_DATA: tx_bit_c = txd_r[bit_idx(fcnt_r)];
        F_CRC: tx_bit_c = crc_r[14];
        default: tx_bit_c = 1'b1;
      endcase
    end
  end

  // A receiver with a clean frame pulls the ack slot dominant
  assign drive_c = tx_act_r ? tx_bit_c :
    ~(fld_r == F_ACK & ok_r & crc_r == 15'h0000);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      can_tx_o <= 1'b1;
    end else if (tx_upd) begin
      can_tx_o <= drive_c;
    end
  end

  assign err_ev = sample & ((stuff_now & b == last_r) |
    (fld_r inside {F_CRCD, F_ACKD, F_EOF} & ~b) |
    (fld_r == F_CRCD & crc_r != 15'h0000));
  assign ack_ev = sample & fld_r == F_ACK & tx_act_r & ~b;
  assign end_ev = sample & fld_r == F_EOF & fcnt_r == EOF_LAST;

  // Frame engine, advanced once per sample point on the destuffed stream
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fld_r <= F_IDLE;
      fcnt_r <= 6'h00;
      run_r <= 3'h0;
      last_r <= 1'b1;
      crc_r <= 15'h0000;
      tx_act_r <= 1'b0;
      ok_r <= 1'b0;
      nb_r <= 4'h0;
      rx_id_r <= 11'h000;
      rx_rtr_r <= 1'b0;
      rx_dlc_r <= 4'h0;
      rxd_r <= '0;
    end else if (sample) begin
      if (err_ev)
        ok_r <= 1'b0;
      if (stuff_now) begin
        run_r <= 3'h1;
        last_r <= b;
      end else begin
        if (in_stuff | fld_r == F_IDLE) begin
          run_r <= (b == last_r && in_stuff) ? run_r + 3'h1 : 3'h1;
          last_r <= b;
        end
        if (fld_r == F_IDLE | fld_r == F_SOF)
          crc_r <= crc_step(15'h0000, b);
        else if (in_stuff)
          crc_r <= crc_step(crc_r, b);
        if (tx_act_r & (fld_r == F_ID | fld_r == F_RTR) & tx_bit_c & ~b)
          tx_act_r <= 1'b0;
        fcnt_r <= fcnt_r + 6'h01;
        unique case (fld_r)
          F_IDLE: begin
            fcnt_r <= 6'h00;
            ok_r <= 1'b1;
            if (~b)
              fld_r <= F_ID;
            else if (send_r) begin
              fld_r <= F_SOF;
              tx_act_r <= 1'b1;
            end
          end
          F_SOF: begin
            fld_r <= F_ID;
            fcnt_r <= 6'h00;
          end
          F_ID: begin
            rx_id_r <= {rx_id_r[9:0], b};
            if (fcnt_r == ID_LAST) begin
              fld_r <= F_RTR;
              fcnt_r <= 6'h00;
            end
          end
          F_RTR: begin
            rx_rtr_r <= b;
            fld_r <= F_RES;
            fcnt_r <= 6'h00;
          end
          F_RES: begin
            if (fcnt_r == RES_LAST) begin
              fld_r <= F_DLC;
              fcnt_r <= 6'h00;
            end
          end
          F_DLC: begin
            rx_dlc_r <= {rx_dlc_r[2:0], b};
            if (fcnt_r == DLC_LAST) begin
              nb_r <= n_bytes(rx_rtr_r, {rx_dlc_r[2:0], b});
              fld_r <= n_bytes(rx_rtr_r, {rx_dlc_r[2:0], b}) == 4'h0 ?
                F_CRC : F_DATA;
              fcnt_r <= 6'h00;
            end
          end
          F_DATA: begin
            rxd_r[bit_idx(fcnt_r)] <= b;
            if (fcnt_r[5:3] == 3'(nb_r - 4'h1) && fcnt_r[2:0] == 3'h7) begin
              fld_r <= F_CRC;
              fcnt_r <= 6'h00;
            end
          end
          F_CRC: begin
            if (fcnt_r == CRC_LAST)
              fld_r <= F_CRCD;
          end
          F_CRCD: fld_r <= F_ACK;
          F_ACK: fld_r <= F_ACKD;
          F_ACKD: begin
            fld_r <= F_EOF;
            fcnt_r <= 6'h00;
          end
          F_EOF: begin
            if (fcnt_r == EOF_LAST) begin
              fld_r <= F_INT;
              fcnt_r <= 6'h00;
            end
          end
          F_INT: begin
            if (fcnt_r == INT_LAST) begin
              fld_r <= F_IDLE;
              tx_act_r <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_sync_len;
    seg_r == SEG_SYNC && ce_i |=> seg_r == SEG_ONE && cnt_r == 5'h00;
  endproperty
  a_sync_len: assert property (p_sync_len)
    else $error("sync segment longer than one cycle");

  property p_one_sync;
    (restart | lengthen | shorten) |-> !synced_r;
  endproperty
  a_one_sync: assert property (p_one_sync)
    else $error("second synchronization in one bit");

  property p_hard;
    hard_ev |=> seg_r == SEG_ONE && cnt_r == 5'h00;
  endproperty
  a_hard: assert property (p_hard)
    else $error("idle falling edge did not restart timing");

  property p_len;
    lengthen |=> ext_r == $past(sjw_len) && seg_r == SEG_ONE;
  endproperty
  a_len: assert property (p_len)
    else $error("lengthen not by jump width");

  property p_short;
    shorten |=> shr_r == $past(sjw_len) && seg_r == SEG_TWO;
  endproperty
  a_short: assert property (p_short)
    else $error("shorten not by jump width");

  property p_sample;
    sample |-> cnt_r == 5'(tim_r[TIM_PRE +: 4]) + ext_r;
  endproperty
  a_sample: assert property (p_sample)
    else $error("sample point not at end of pre-sample segment");

  property p_seg2;
    seg_r == SEG_TWO |-> cnt_r < 5'(tim_r[TIM_POST +: 3]) + 5'h01;
  endproperty
  a_seg2: assert property (p_seg2)
    else $error("post-sample segment overrun");

  property p_stuff;
    tx_upd && tx_act_r && stuff_now |=> can_tx_o == !$past(last_r);
  endproperty
  a_stuff: assert property (p_stuff)
    else $error("stuff bit not complementary");

  property p_eof;
    tx_upd && fld_r == F_EOF |=> can_tx_o;
  endproperty
  a_eof: assert property (p_eof)
    else $error("dominant bit driven in end of frame");

  property p_sof;
    tx_upd && tx_act_r && fld_r == F_SOF |=> !can_tx_o;
  endproperty
  a_sof: assert property (p_sof)
    else $error("start bit not dominant");

  property p_skip;
    skip_c |-> !restart && !lengthen;
  endproperty
  a_skip: assert property (p_skip)
    else $error("transmitter resynced on positive error");
endmodule : canbf_core
`default_nettype wire

/* File: sim/canbf_node_model.sv */
// Behavioural far-side CAN node: sends bit streams, records bus bits, acks.
// Assumes the bench ANDs tx_o with the device output to form the bus.
`timescale 1ns/1ps
`default_nettype none
module canbf_node_model (
  input wire logic clk_i,
  input wire logic bus_i,
  input wire logic [4:0] bitlen_i,
  output logic tx_o
);
  logic snd_r = 1'b1;
  logic ack_r = 1'b0;
  logic last_r = 1'b1;
  logic run_r = 1'b0;
  int cnt = 0;
  int rec_n = 0;
  int ack_idx = -1;
  logic rec [0:255];
  // Released line reads recessive; dominant from any source wins
  assign tx_o = snd_r & ~ack_r;
  task automatic arm(input int ack_at);
    rec_n = 0;
    run_r = 1'b0;
    ack_idx = ack_at;
  endtask : arm
  // Caller enters just after a rising edge
  task automatic send(input logic b[$], input int p);
    foreach (b[i]) begin
      snd_r <= b[i];
      repeat (p) @(posedge clk_i);
    end
    snd_r <= 1'b1;
  endtask : send
  always @(posedge clk_i) begin
    last_r <= bus_i;
    if (bus_i !== last_r) begin
      // Every edge restarts the bit so drift never builds up
      cnt <= 0;
      if (!bus_i) begin
        run_r <= 1'b1;
      end
    end else if (cnt >= bitlen_i - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
    if (run_r && cnt == bitlen_i / 2 && rec_n < 256) begin
      rec[rec_n] <= bus_i;
      rec_n <= rec_n + 1;
    end
    if (run_r && cnt == bitlen_i - 1) begin
      ack_r <= (rec_n == ack_idx) && !ack_r;
    end
  end
endmodule : canbf_node_model
`default_nettype wire

/* File: sim/tb_can_bit_sync_and_frame_format.sv */
// Testbench: APB register access, frame transmit and receive on the bus.
// Assumes the node model on the far side and a 20 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module tb_can_bit_sync_and_frame_format;
  import canbf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic can_tx;
  logic node_tx;
  logic bus;
  logic [4:0] bitlen = 5'h0D;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hF;
  logic fr[$];
  int ack_pos;
  int error_cnt = 0;
  int check_count = 0;
  logic [31:0] q;
  logic e;
  assign bus = can_tx & node_tx;
  always #25 clk = ~clk;
  canbf_core DUT (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .can_rx_i(bus), .can_tx_o(can_tx));
  canbf_node_model node (.clk_i(clk), .bus_i(bus), .bitlen_i(bitlen),
    .tx_o(node_tx));
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h0000_0001, {31'h0, pready});
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string nm, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, ex, q & m);
  endtask : rd
  // Frame as it should appear on the bus, stuffing applied up to CRC end
  task automatic build(input logic [10:0] id, input logic rtr,
      input logic [3:0] dlc, input logic [63:0] dat, input logic ackv);
    logic raw[$];
    logic [14:0] crc;
    int run;
    int nb;
    raw = {};
    crc = 15'h0000;
    nb = rtr ? 0 : ((dlc > 8) ? 8 : dlc);
    raw.push_back(1'b0);
    for (int i = 10; i >= 0; i--) raw.push_back(id[i]);
    raw.push_back(rtr);
    raw.push_back(1'b0);
    raw.push_back(1'b0);
    for (int i = 3; i >= 0; i--) raw.push_back(dlc[i]);
    for (int k = 0; k < nb; k++)
      for (int i = 7; i >= 0; i--) raw.push_back(dat[8*k+i]);
    foreach (raw[i])
      crc = {crc[13:0], 1'b0} ^ ((raw[i] ^ crc[14]) ? CRC_POLY : 15'h0000);
    for (int i = 14; i >= 0; i--) raw.push_back(crc[i]);
    fr = {};
    run = 0;
    foreach (raw[i]) begin
      if (fr.size() > 0 && raw[i] == fr[$])
        run++;
      else
        run = 1;
      fr.push_back(raw[i]);
      if (run == 5) begin
        fr.push_back(!raw[i]);
        run = 1;
      end
    end
    fr.push_back(1'b1);
    ack_pos = fr.size();
    fr.push_back(ackv);
    for (int i = 0; i < 8; i++) fr.push_back(1'b1);
  endtask : build
  initial begin
    #2000000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("tx idle", 32'h0000_0001, {31'h0, can_tx});
    rd("ctrl", ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RST);
    rd("tim", ADDR_TIM, 32'hFFFF_FFFF, TIM_RST);
    // No lane strobed: the write must leave the timing untouched
    pstrb <= 4'h0;
    apb(1'b1, ADDR_TIM, 32'h0000_0000);
    pstrb <= 4'hF;
    rd("tim strb", ADDR_TIM, 32'hFFFF_FFFF, TIM_RST);
    // Clock enable low stalls the bus answer
    ce <= 1'b0;
    @(posedge clk);
    chk("pready ce", 32'h0000_0000, {31'h0, pready});
    ce <= 1'b1;
    rd("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    // Data frame, then remote frame whose length code must send no bytes
    for (int t = 0; t < 2; t++) begin
      build(11'h0F8, t[0], t ? 4'h3 : 4'h2, 64'h0000_0000_0000_0FFF, 1'b0);
      node.arm(ack_pos);
      apb(1'b1, ADDR_TXID, {16'h0, (t ? 4'h3 : 4'h2), t[0], 11'h0F8});
      apb(1'b1, ADDR_TXD0, 32'h0000_0FFF);
      apb(1'b1, ADDR_CTRL, 32'h0000_0002);
      repeat ((fr.size() + 6) * 13) @(posedge clk);
      foreach (fr[i])
        chk("tx bit", {31'h0, fr[i]}, {31'h0, node.rec[i]});
      rd("tx stat", ADDR_STAT, 32'h0000_000F, 32'h0000_000D);
      apb(1'b1, ADDR_STAT, 32'h0000_003C);
      rd("stat clr", ADDR_STAT, 32'h0000_003C, 32'h0000_0000);
    end
    // Receive at nominal rate, then a slower sender with both-edge resync
    for (int t = 0; t < 2; t++) begin
      if (t == 1) begin
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, ADDR_TIM, 32'h0000_0337);
        rd("tim", ADDR_TIM, 32'hFFFF_FFFF, 32'h0000_0337);
      end
      bitlen <= t ? 5'h0E : 5'h0D;
      build(11'h2B4, 1'b0, 4'h3, 64'h0000_0000_0081_00FF, 1'b1);
      node.arm(-1);
      @(posedge clk);
      node.send(fr, t ? 14 : 13);
      repeat (60) @(posedge clk);
      chk("ack slot", 32'h0, {31'h0, node.rec[ack_pos]});
      rd("rxid", ADDR_RXID, 32'hFFFF_FFFF, 32'h0000_32B4);
      rd("rxd0", ADDR_RXD0, 32'hFFFF_FFFF, 32'h0081_00FF);
      rd("rx stat", ADDR_STAT, 32'h0000_0030, 32'h0000_0010);
      apb(1'b1, ADDR_STAT, 32'h0000_003C);
    end
    test_done();
  end
endmodule : tb_can_bit_sync_and_frame_format
`default_nettype wire
